// ==== design/fifo_batch_pkg.sv ====
// Constants, encodings and register layout for the FIFO batch block
package fifo_batch_pkg;

  localparam logic [7:0] ADDR_RATE    = 8'h09;
  localparam logic [7:0] ADDR_MODE    = 8'h0A;
  localparam logic [7:0] ADDR_CNT_HI  = 8'h0B;
  localparam logic [7:0] ADDR_CNT_LO  = 8'h0C;
  localparam logic [7:0] ADDR_INT1    = 8'h0D;
  localparam logic [7:0] ADDR_STATUS2 = 8'h3B;

  // Field positions
  localparam int GY_LSB       = 4;
  localparam int XL_LSB       = 0;
  localparam int DEC_LSB      = 6;
  localparam int TEMP_LSB     = 4;
  localparam int MODE_LSB     = 0;
  localparam int PULSED_BIT   = 7;
  localparam int CLEAR_BIT    = 6;
  localparam int SOURCE_BIT   = 5;
  localparam int THR_HI_LSB   = 0;
  localparam int INT1_EN_BIT  = 6;
  localparam int FLAG_BIT     = 6;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'hF7;
  localparam logic [7:0] CNT_WMASK  = 8'hA7;

  localparam logic [2:0] MODE_BYPASS    = 3'h0;
  localparam logic [2:0] MODE_STOP      = 3'h1;
  localparam logic [2:0] MODE_CONT_STOP = 3'h3;
  localparam logic [2:0] MODE_BYP_CONT  = 3'h4;
  localparam logic [2:0] MODE_CONT      = 3'h6;
  localparam logic [2:0] MODE_BYP_STOP  = 3'h7;

  typedef enum logic [1:0] {OP_BYPASS = 2'b00, OP_STOP = 2'b01, OP_CONT = 2'b11} op_e;
  typedef enum logic {PH_FIRST = 1'b0, PH_SECOND = 1'b1} phase_e;

  // Rate ladder: code 1010 is the base tick, each step down halves it
  localparam logic [3:0] RATE_TOP_CODE  = 4'hA;
  localparam logic [3:0] RATE_SLOW_CODE = 4'hB;
  localparam logic [4:0] GY_SLOW_SHIFT  = 5'd10;
  localparam logic [4:0] XL_SLOW_SHIFT  = 5'd12;
  localparam logic [4:0] TEMP_SHIFT_1   = 5'd12;
  localparam logic [4:0] TEMP_SHIFT_2   = 5'd9;
  localparam logic [4:0] TEMP_SHIFT_3   = 5'd7;
  localparam logic [4:0] DEC_SHIFT_8    = 5'd3;
  localparam logic [4:0] DEC_SHIFT_32   = 5'd5;
  localparam logic [4:0] SHIFT_NONE     = 5'd31;
  localparam int         LADDER_W       = 17;

  localparam int CLK_HZ         = 10_000_000;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int BASE_RATE_HZ   = 6667;
  localparam int BASE_TICK_CYC  = CLK_HZ / BASE_RATE_HZ;
  localparam int DRDY_PULSE_NS  = 75_000;
  localparam int DRDY_PULSE_CYC = (DRDY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] TAG_GYRO  = 2'h0;
  localparam logic [1:0] TAG_ACCEL = 2'h1;
  localparam logic [1:0] TAG_TEMP  = 2'h2;
  localparam logic [1:0] TAG_TIME  = 2'h3;

endpackage : fifo_batch_pkg

// ==== design/sample_queue.sv ====
// Sample FIFO with optional overwrite of the oldest entry
`timescale 1ns/1ps
`default_nettype none
module sample_queue #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             overwrite,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             full, do_push, do_pop, drop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : bump

  assign full      = (count == (AW+1)'(DEPTH));
  assign in_ready  = !full || overwrite;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_comb begin
    do_push     = in_valid && in_ready;
    do_pop      = out_valid && out_ready;
    // Full and no reader: the oldest entry makes room
    drop        = do_push && full && !do_pop;
    next_wr_ptr = do_push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = (do_pop || drop) ? bump(rd_ptr) : rd_ptr;
    next_count  = count;
    if (do_push && !do_pop && !drop) begin
      next_count = count + (AW+1)'(1);
    end else if (do_pop && !do_push) begin
      next_count = count - (AW+1)'(1);
    end
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (do_push && !flush) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : sample_queue
`default_nettype wire

// ==== design/fifo_batch_ctrl.sv ====
// Batch-rate, FIFO-mode, data-ready and batch-counter control
`timescale 1ns/1ps
`default_nettype none
module fifo_batch_ctrl
  import fifo_batch_pkg::*;
#(
  parameter int DATA_W     = 16,
  parameter int FIFO_DEPTH = 32,
  parameter int TICK_CYC   = BASE_TICK_CYC,
  parameter int PULSE_CYC  = DRDY_PULSE_CYC
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_we,
  input  wire logic                reg_re,
  output logic [7:0]               reg_rdata,
  input  wire logic [DATA_W-1:0]   accel_sample,
  input  wire logic [DATA_W-1:0]   gyro_sample,
  input  wire logic [DATA_W-1:0]   temp_sample,
  input  wire logic [DATA_W-1:0]   time_sample,
  input  wire logic                mode_trigger,
  output logic [DATA_W+1:0]        fifo_out_data,
  output logic                     fifo_out_valid,
  input  wire logic                fifo_out_ready,
  output logic                     drdy,
  output logic                     int1
);
  localparam int QW = DATA_W + 2;

  // Register state
  logic [7:0] rate_reg, mode_reg, cnt_hi_reg, cnt_lo_reg, int1_reg;
  logic [7:0] next_rate_reg, next_mode_reg, next_cnt_hi_reg, next_cnt_lo_reg, next_int1_reg;
  logic [7:0] next_reg_rdata;
  logic       wr_rate, wr_mode, wr_cnt_hi, counter_clear, status_read;

  logic [3:0] gyro_batch_rate, accel_batch_rate;
  logic [1:0] timestamp_decimation, temperature_batch_rate;
  logic [2:0] fifo_mode;
  logic       dataready_pulsed, batch_counter_source, pin1_batch_flag_enable;
  logic [10:0] batch_counter_threshold;

  always_comb begin
    wr_rate       = reg_we && (reg_addr == ADDR_RATE);
    wr_mode       = reg_we && (reg_addr == ADDR_MODE);
    wr_cnt_hi     = reg_we && (reg_addr == ADDR_CNT_HI);
    counter_clear = wr_cnt_hi && reg_wdata[CLEAR_BIT];
    status_read   = reg_re && (reg_addr == ADDR_STATUS2);
    next_rate_reg   = wr_rate ? reg_wdata : rate_reg;
    // Reserved and self-clearing bits are never stored
    next_mode_reg   = wr_mode ? (reg_wdata & MODE_WMASK) : mode_reg;
    next_cnt_hi_reg = wr_cnt_hi ? (reg_wdata & CNT_WMASK) : cnt_hi_reg;
    next_cnt_lo_reg = (reg_we && reg_addr == ADDR_CNT_LO) ? reg_wdata : cnt_lo_reg;
    next_int1_reg   = (reg_we && reg_addr == ADDR_INT1) ? reg_wdata : int1_reg;
  end

  assign gyro_batch_rate         = rate_reg[GY_LSB +: 4];
  assign accel_batch_rate        = rate_reg[XL_LSB +: 4];
  assign timestamp_decimation    = mode_reg[DEC_LSB +: 2];
  assign temperature_batch_rate  = mode_reg[TEMP_LSB +: 2];
  assign fifo_mode               = mode_reg[MODE_LSB +: 3];
  assign dataready_pulsed        = cnt_hi_reg[PULSED_BIT];
  assign batch_counter_source    = cnt_hi_reg[SOURCE_BIT];
  assign batch_counter_threshold = {cnt_hi_reg[THR_HI_LSB +: 3], cnt_lo_reg};
  assign pin1_batch_flag_enable  = int1_reg[INT1_EN_BIT];

  // Rate generation: one base tick divided by powers of two
  function automatic logic [4:0] rate_shift(input logic [3:0] code, input logic [4:0] slow);
    if (code >= 4'h1 && code <= RATE_TOP_CODE) begin
      return 5'(RATE_TOP_CODE - code);
    end else if (code == RATE_SLOW_CODE) begin
      return slow;
    end
    return SHIFT_NONE;
  endfunction : rate_shift

  function automatic logic ladder_hit(input logic [LADDER_W-1:0] cnt, input logic [4:0] sh);
    logic [LADDER_W-1:0] mask;
    mask = ~({LADDER_W{1'b1}} << sh);
    return (sh != SHIFT_NONE) && ((cnt & mask) == '0);
  endfunction : ladder_hit

  logic [11:0]         tick_cnt, next_tick_cnt;
  logic [LADDER_W-1:0] ladder, next_ladder;
  logic                base_tick;
  logic [4:0]          gy_sh, xl_sh, temp_sh, ts_sh, fast_sh;
  logic                gy_ev, xl_ev, temp_ev, ts_ev;

  always_comb begin
    base_tick     = (tick_cnt == 12'(TICK_CYC - 1));
    next_tick_cnt = base_tick ? 12'h000 : tick_cnt + 12'h001;
    next_ladder   = base_tick ? ladder + LADDER_W'(1) : ladder;
    gy_sh   = rate_shift(gyro_batch_rate, GY_SLOW_SHIFT);
    xl_sh   = rate_shift(accel_batch_rate, XL_SLOW_SHIFT);
    fast_sh = (gy_sh < xl_sh) ? gy_sh : xl_sh;
    case (timestamp_decimation)
      2'b01:   ts_sh = fast_sh;
      2'b10:   ts_sh = (fast_sh == SHIFT_NONE) ? SHIFT_NONE : fast_sh + DEC_SHIFT_8;
      2'b11:   ts_sh = (fast_sh == SHIFT_NONE) ? SHIFT_NONE : fast_sh + DEC_SHIFT_32;
      default: ts_sh = SHIFT_NONE;
    endcase
    case (temperature_batch_rate)
      2'b01:   temp_sh = TEMP_SHIFT_1;
      2'b10:   temp_sh = TEMP_SHIFT_2;
      2'b11:   temp_sh = TEMP_SHIFT_3;
      default: temp_sh = SHIFT_NONE;
    endcase
    gy_ev   = base_tick && ladder_hit(ladder, gy_sh);
    xl_ev   = base_tick && ladder_hit(ladder, xl_sh);
    temp_ev = base_tick && ladder_hit(ladder, temp_sh);
    ts_ev   = base_tick && ladder_hit(ladder, ts_sh);
  end

  // Trigger: two-stage synchroniser, third stage for the edge
  logic   trig_s1, trig_s2, trig_s3, trig_fall;
  phase_e phase, next_phase;
  op_e    op;

  assign trig_fall = trig_s3 && !trig_s2;

  always_comb begin
    next_phase = phase;
    if (wr_mode) begin
      next_phase = PH_FIRST;
    end else if (trig_fall) begin
      next_phase = PH_SECOND;
    end
    case (fifo_mode)
      MODE_STOP:      op = OP_STOP;
      MODE_CONT:      op = OP_CONT;
      MODE_CONT_STOP: op = (phase == PH_FIRST) ? OP_CONT : OP_STOP;
      MODE_BYP_CONT:  op = (phase == PH_FIRST) ? OP_BYPASS : OP_CONT;
      MODE_BYP_STOP:  op = (phase == PH_FIRST) ? OP_BYPASS : OP_STOP;
      default:        op = OP_BYPASS;
    endcase
  end

  // Pending writes, one FIFO entry per cycle, gyro first
  logic [3:0]    pend, next_pend, new_ev, served;
  logic [QW-1:0] q_in_data;
  logic          q_in_valid, q_in_ready;
  logic [DATA_W-1:0] src_data [4];

  assign new_ev      = {ts_ev, temp_ev, xl_ev, gy_ev};
  assign src_data[0] = gyro_sample;
  assign src_data[1] = accel_sample;
  assign src_data[2] = temp_sample;
  assign src_data[3] = time_sample;

  always_comb begin
    served    = 4'h0;
    q_in_data = {TAG_GYRO, gyro_sample};
    for (int i = 3; i >= 0; i--) begin
      if (pend[i]) begin
        served    = 4'(1 << i);
        q_in_data = {2'(i), src_data[i]};
      end
    end
    q_in_valid = (op != OP_BYPASS) && (pend != 4'h0);
    // Stop-when-full holds the entry; later events merge and are lost
    if (!(q_in_valid && q_in_ready)) begin
      served = 4'h0;
    end
    next_pend = (op == OP_BYPASS) ? 4'h0 : ((pend & ~served) | new_ev);
  end

  sample_queue #(
    .WIDTH (QW),
    .DEPTH (FIFO_DEPTH)
  ) sample_queue_i (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .flush     (op == OP_BYPASS),
    .overwrite (op == OP_CONT),
    .in_valid  (q_in_valid),
    .in_data   (q_in_data),
    .in_ready  (q_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_out_ready)
  );

  // Data-ready, batch counter and threshold flag
  logic        dr_ev, next_drdy, src_ev, thr_hit;
  logic [9:0]  pulse_cnt, next_pulse_cnt;
  logic [10:0] batch_count, next_batch_count;
  logic        batch_threshold_flag, next_flag, next_int1;

  always_comb begin
    dr_ev          = gy_ev || xl_ev;
    next_pulse_cnt = (pulse_cnt != 10'h000) ? pulse_cnt - 10'h001 : 10'h000;
    if (dataready_pulsed) begin
      if (dr_ev) begin
        next_pulse_cnt = 10'(PULSE_CYC - 1);
      end
      next_drdy = dr_ev || (pulse_cnt != 10'h000);
    end else begin
      next_drdy = dr_ev || (drdy && !reg_re);
    end
    src_ev  = batch_counter_source ? gy_ev : xl_ev;
    thr_hit = src_ev && !counter_clear && (batch_counter_threshold != 11'h000)
              && (batch_count + 11'h001 == batch_counter_threshold);
    if (counter_clear) begin
      next_batch_count = 11'h000;
    end else if (thr_hit) begin
      next_batch_count = 11'h000;
    end else if (src_ev) begin
      next_batch_count = batch_count + 11'h001;
    end else begin
      next_batch_count = batch_count;
    end
    // A new hit wins over a clearing read
    next_flag = thr_hit || (batch_threshold_flag && !status_read);
    // Enable taken from its next value so the pin never lags a fresh enable
    next_int1 = next_flag && next_int1_reg[INT1_EN_BIT];
    case (reg_addr)
      ADDR_RATE:    next_reg_rdata = rate_reg;
      ADDR_MODE:    next_reg_rdata = mode_reg;
      ADDR_CNT_HI:  next_reg_rdata = cnt_hi_reg;
      ADDR_CNT_LO:  next_reg_rdata = cnt_lo_reg;
      ADDR_INT1:    next_reg_rdata = int1_reg;
      ADDR_STATUS2: next_reg_rdata = 8'(batch_threshold_flag) << FLAG_BIT;
      default:      next_reg_rdata = 8'h00;
    endcase
    if (!reg_re) begin
      next_reg_rdata = reg_rdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rate_reg   <= RESET_BYTE;
      mode_reg   <= RESET_BYTE;
      cnt_hi_reg <= RESET_BYTE;
      cnt_lo_reg <= RESET_BYTE;
      int1_reg   <= RESET_BYTE;
      reg_rdata  <= 8'h00;
      tick_cnt   <= 12'h000;
      ladder     <= '0;
      trig_s1    <= 1'b0;
      trig_s2    <= 1'b0;
      trig_s3    <= 1'b0;
      phase      <= PH_FIRST;
      pend       <= 4'h0;
      drdy       <= 1'b0;
      pulse_cnt  <= 10'h000;
      batch_count          <= 11'h000;
      batch_threshold_flag <= 1'b0;
      int1       <= 1'b0;
    end else begin
      rate_reg   <= next_rate_reg;
      mode_reg   <= next_mode_reg;
      cnt_hi_reg <= next_cnt_hi_reg;
      cnt_lo_reg <= next_cnt_lo_reg;
      int1_reg   <= next_int1_reg;
      reg_rdata  <= next_reg_rdata;
      tick_cnt   <= next_tick_cnt;
      ladder     <= next_ladder;
      trig_s1    <= mode_trigger;
      trig_s2    <= trig_s1;
      trig_s3    <= trig_s2;
      phase      <= next_phase;
      pend       <= next_pend;
      drdy       <= next_drdy;
      pulse_cnt  <= next_pulse_cnt;
      batch_count          <= next_batch_count;
      batch_threshold_flag <= next_flag;
      int1       <= next_int1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence seq_clear_write;
    counter_clear;
  endsequence
  sequence seq_fall_in_mode(logic [2:0] m);
    trig_fall && fifo_mode == m && !wr_mode;
  endsequence

  AST_GY_OFF: assert property (gyro_batch_rate == 4'h0 |-> !gy_ev)
    else $error("gyro event with rate off");
  AST_XL_OFF: assert property (accel_batch_rate == 4'h0 |-> !xl_ev)
    else $error("accel event with rate off");
  AST_BYPASS_EMPTY: assert property (fifo_mode == MODE_BYPASS |=> !fifo_out_valid)
    else $error("fifo not empty in bypass");
  AST_STOP_HOLD: assert property (op == OP_STOP && !q_in_ready && !fifo_out_ready && !wr_mode
                                  |=> !q_in_ready && $stable(fifo_out_data))
    else $error("write taken while full in stop mode");
  AST_CLEAR: assert property (seq_clear_write |=> batch_count == 11'h000)
    else $error("counter not cleared");
  AST_THRESH: assert property (thr_hit |=> batch_threshold_flag && batch_count == 11'h000)
    else $error("threshold did not reset counter and set flag");
  AST_PULSE: assert property (dataready_pulsed && dr_ev |=> drdy [*8])
    else $error("data-ready pulse too short");
  AST_LATCH: assert property (!dataready_pulsed && drdy && !reg_re && !dr_ev |=> drdy)
    else $error("latched data-ready dropped without read");
  AST_INT1: assert property (batch_threshold_flag && pin1_batch_flag_enable |-> int1)
    else $error("pin 1 not driven by flag");
  AST_CONT_TO_STOP: assert property (seq_fall_in_mode(MODE_CONT_STOP) |=> op == OP_STOP)
    else $error("no switch to stop mode after trigger");
  AST_BYP_TO_CONT: assert property (seq_fall_in_mode(MODE_BYP_CONT) |=> op == OP_CONT)
    else $error("no switch to continuous after trigger");
endmodule : fifo_batch_ctrl
`default_nettype wire

// ==== tb/host_model.sv ====
// Host-side model: register strobes and FIFO drain
`timescale 1ns/1ps
`default_nettype none
module host_model
  import fifo_batch_pkg::*;
(
  input  wire logic        ref_clk,
  output logic [7:0]       reg_addr,
  output logic [7:0]       reg_wdata,
  output logic             reg_we,
  output logic             reg_re,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic [17:0] fifo_out_data,
  input  wire logic        fifo_out_valid,
  output logic             fifo_out_ready
);
  logic [17:0] got [$];
  int          timeouts;

  initial begin
    reg_addr       = 8'h00;
    reg_wdata      = 8'h00;
    reg_we         = 1'b0;
    reg_re         = 1'b0;
    fifo_out_ready = 1'b0;
    timeouts       = 0;
  end

  // Idle lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr  = a;
    reg_wdata = (a == ADDR_MODE) ? (d & 8'hF7) : (a == ADDR_CNT_HI) ? (d & 8'hE7) : d;
    reg_we    = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_we    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~reg_wdata;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_re   = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_re   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask : rd

  // Pops n entries; samples at the falling edge so the pop edge is unambiguous
  task automatic drain(input int n, input int lim);
    int w;
    w = 0;
    got.delete();
    @(posedge ref_clk);
    #1;
    fifo_out_ready = 1'b1;
    while (got.size() < n && w < lim) begin
      @(negedge ref_clk);
      if (fifo_out_valid === 1'b1) got.push_back(fifo_out_data);
      else w++;
      @(posedge ref_clk);
    end
    #1;
    fifo_out_ready = 1'b0;
    if (got.size() < n) timeouts++;
  endtask : drain
endmodule : host_model
`default_nettype wire

// ==== tb/fifo_batch_ctrl_bench.sv ====
// Self-checking bench for the FIFO batch control block
`timescale 1ns/1ps
`default_nettype none
module fifo_batch_ctrl_bench
  import fifo_batch_pkg::*;
;
  localparam int TICK  = 4;
  localparam int PULSE = 10;

  logic        ref_clk, rst, reg_we, reg_re, mode_trigger;
  logic        fifo_out_valid, fifo_out_ready, drdy, int1;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
  logic [15:0] stamp = 16'h0000;
  logic [15:0] t;
  logic [17:0] fifo_out_data;
  int          n_mismatch, tests_run, k;
  logic [7:0]  rate_v [8] = '{8'hA0, 8'h90, 8'h10, 8'hB0, 8'h0A, 8'h01, 8'h0B, 8'h00};
  logic [7:0]  ctl_v  [8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h31};
  int          step_v [8] = '{1, 2, 512, 1024, 1, 512, 4096, 128};
  logic [1:0]  tag_v  [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2};
  logic [7:0]  regs_v [7] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h3B, 8'h20};
  logic [2:0]  mode_v [8] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h3, 3'h4, 3'h7};
  logic        fill_v [8] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  fifo_batch_ctrl #(.TICK_CYC(TICK), .PULSE_CYC(PULSE)) fifo_batch_ctrl_i (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .accel_sample(stamp), .gyro_sample(stamp), .temp_sample(stamp), .time_sample(stamp),
    .mode_trigger(mode_trigger), .fifo_out_data(fifo_out_data),
    .fifo_out_valid(fifo_out_valid), .fifo_out_ready(fifo_out_ready),
    .drdy(drdy), .int1(int1));

  host_model host_model_i (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .fifo_out_data(fifo_out_data),
    .fifo_out_valid(fifo_out_valid), .fifo_out_ready(fifo_out_ready));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Sample words are a running stamp, so strides reveal the write rate
  always @(posedge ref_clk) stamp <= #1 stamp + 16'h0001;

  task automatic wrap_up();
    n_mismatch += host_model_i.timeouts;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic pull(input int n);
    // Slowest accel code needs two strides of 16384 cycles
    host_model_i.drain(n, 40000);
    if (host_model_i.timeouts != 0) wrap_up();
  endtask : pull

  task automatic wait_high(input logic which, input int lim);
    int i;
    i = 0;
    @(negedge ref_clk);
    while ((which ? int1 : drdy) !== 1'b1 && i < lim) begin
      @(negedge ref_clk);
      i++;
    end
    check("wait", 32'(i < lim), 32'h1);
    if (i >= lim) wrap_up();
  endtask : wait_high

  initial begin
    n_mismatch   = 0;
    tests_run    = 0;
    rst          = 1'b1;
    mode_trigger = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      host_model_i.rd(regs_v[i], v);
      check("reset value", 32'(v), 32'h0);
    end
    host_model_i.wr(ADDR_RATE, 8'hAA);
    host_model_i.rd(ADDR_RATE, v);
    check("rate reg", 32'(v), 32'hAA);
    host_model_i.wr(ADDR_CNT_HI, 8'hC5);
    host_model_i.rd(ADDR_CNT_HI, v);
    check("counter reg", 32'(v), 32'h85);
    host_model_i.wr(ADDR_CNT_HI, 8'h00);
    host_model_i.wr(ADDR_RATE, 8'h0A);
    // Plain modes, then triggered modes before and after the falling trigger
    for (int i = 0; i < 8; i++) begin
      mode_trigger = (i >= 5);
      host_model_i.wr(ADDR_MODE, 8'h00);
      host_model_i.wr(ADDR_MODE, {5'h00, mode_v[i]});
      repeat (40) @(posedge ref_clk);
      #1;
      check("mode fill", 32'(fifo_out_valid), 32'(fill_v[i]));
      if (i >= 5) begin
        mode_trigger = 1'b0;
        repeat (40) @(posedge ref_clk);
        #1;
        check("second phase", 32'(fifo_out_valid), 32'h1);
      end
    end
    for (int m = 0; m < 2; m++) begin
      host_model_i.wr(ADDR_MODE, 8'h00);
      host_model_i.wr(ADDR_MODE, m ? 8'h06 : 8'h01);
      repeat (300) @(posedge ref_clk);
      t = stamp;
      pull(32);
      k = int'(16'(t - host_model_i.got[31][15:0]));
      if (m == 0) check("stop age", 32'(k >= 100), 32'h1);
      else check("cont age", 32'(k < 20), 32'h1);
      if (m == 0) check("stride", 32'(16'(host_model_i.got[31][15:0] - host_model_i.got[0][15:0])), 32'(31 * TICK));
    end
    for (int i = 0; i < 8; i++) begin
      host_model_i.wr(ADDR_MODE, 8'h00);
      host_model_i.wr(ADDR_RATE, rate_v[i]);
      host_model_i.wr(ADDR_MODE, ctl_v[i]);
      pull(2);
      check("rate stride", 32'(16'(host_model_i.got[1][15:0] - host_model_i.got[0][15:0])), 32'(step_v[i] * TICK));
      check("tag a", 32'(host_model_i.got[0][17:16]), 32'(tag_v[i]));
      check("tag b", 32'(host_model_i.got[1][17:16]), 32'(tag_v[i]));
    end
    host_model_i.wr(ADDR_MODE, 8'h00);
    host_model_i.wr(ADDR_RATE, 8'hA0);
    host_model_i.wr(ADDR_MODE, 8'h41);
    pull(32);
    k = 0;
    foreach (host_model_i.got[i]) k += (host_model_i.got[i][17:16] == TAG_TIME);
    check("stamp count", 32'(k), 32'd16);
    // Counter: wrong source stays quiet, right source fires
    host_model_i.wr(ADDR_MODE, 8'h06);
    host_model_i.wr(ADDR_CNT_LO, 8'h03);
    host_model_i.wr(ADDR_INT1, 8'h40);
    host_model_i.wr(ADDR_RATE, 8'h0A);
    host_model_i.wr(ADDR_CNT_HI, 8'h60);
    repeat (60) @(posedge ref_clk);
    #1;
    check("int1 gyro source", 32'(int1), 32'h0);
    host_model_i.wr(ADDR_CNT_HI, 8'h00);
    wait_high(1'b1, 60);
    host_model_i.wr(ADDR_RATE, 8'h00);
    host_model_i.rd(ADDR_STATUS2, v);
    check("flag set", 32'(v), 32'h40);
    host_model_i.rd(ADDR_STATUS2, v);
    check("flag clear", 32'(v), 32'h0);
    check("int1 low", 32'(int1), 32'h0);
    host_model_i.wr(ADDR_CNT_LO, 8'h00);
    host_model_i.wr(ADDR_CNT_HI, 8'h41);
    host_model_i.wr(ADDR_RATE, 8'h0A);
    repeat (1000) @(posedge ref_clk);
    #1;
    check("int1 early", 32'(int1), 32'h0);
    wait_high(1'b1, 60);
    host_model_i.wr(ADDR_CNT_HI, 8'h00);
    wait_high(1'b0, 20);
    host_model_i.wr(ADDR_RATE, 8'h00);
    repeat (20) @(posedge ref_clk);
    #1;
    check("drdy held", 32'(drdy), 32'h1);
    host_model_i.rd(ADDR_RATE, v);
    check("drdy cleared", 32'(drdy), 32'h0);
    host_model_i.wr(ADDR_CNT_HI, 8'h80);
    host_model_i.wr(ADDR_RATE, 8'h01);
    wait_high(1'b0, 2200);
    k = 0;
    while (drdy === 1'b1 && k < 50) begin
      k++;
      @(negedge ref_clk);
    end
    check("pulse length", 32'(k), 32'(PULSE));
    wrap_up();
  end
endmodule : fifo_batch_ctrl_bench
`default_nettype wire
